// ===== hdl/crc_engine_consts.svh
// Purpose: Register addresses, field positions, reset values and constants of the CRC engine.
// Assumes: Included by its bare name from the design file, the checker and the bench.
// Notes: Definitions only.
`ifndef CRC_ENGINE_CONSTS_SVH
`define CRC_ENGINE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define ADDR_RESULT_PORT 8'h91
`define ADDR_CRC_CONTROL 8'h92
`define ADDR_BYTE_INPUT 8'h93
`define ADDR_BIT_REVERSE 8'h94
`define ADDR_AUTO_CONTROL 8'h96
`define ADDR_SECTOR_COUNT 8'h97

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTL_POLY_SEL_BIT 4
`define CTL_PRESET_BIT 3
`define CTL_PRESET_VAL_BIT 2
`define AUTO_ENABLE_BIT 7
`define AUTO_COMPLETE_BIT 6

// ----------------------------------------------------------------------------
// Reset values and arithmetic constants
// ----------------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_AUTO_CONTROL 8'h40
`define RST_RESULT 32'h00000000
`define PRESET_ONES 32'hFFFFFFFF
`define POLY_32 32'h04C11DB7
`define POLY_16 16'h1021
`define SECTOR_SHIFT 10
`define FULL_SPACE_SECTORS 7'h40
`define FIFO_DEPTH 16
`define FIFO_WIDTH 8

`endif

// ===== hdl/crc_engine_pkg.sv
// Purpose: Types shared by the CRC engine.
// Assumes: Constants come from crc_engine_consts.svh.
// Notes: The package holds types only.
package crc_engine_pkg;

  // Special function register access, one request per clock.
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_t;

  // Flash read return.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } flash_rsp_t;

  // Automatic scan sequencer.
  typedef enum logic [1:0] {
    SCAN_IDLE,
    SCAN_REQ,
    SCAN_WAIT,
    SCAN_DRAIN
  } scan_state_t;

endpackage

// ===== hdl/crc_engine_auto_flash_scan.sv
// Purpose: Byte-serial CRC engine with result byte port, bit reverse and automatic flash scan.
// Assumes: Core and flash controller share clk_sys_i; reset is synchronous, active low.
// Notes: The core is stalled while an automatic scan runs.
//
// Operation
// - Each write to the byte input register folds that byte into the stored CRC result.
// - The result port reaches only the result byte chosen by the byte pointer.
// - With auto scan enable set, a control register write launches an automatic scan unless one is already running.
// - The complete flag reads zero while a scan runs and one otherwise.
// - The core is stalled from the launch of a scan until it has finished.
// - The start sector field gives the first sector, at byte address start times 1024.
// - On large parts, start sectors 32 to 63 reach the upper bank chosen by the bank select.
// - The sector count field gives how many sectors a scan includes.
// - Start and count both zero scan the whole 64kB banked code space.
// - The two upper bits of the sector count read as zero and ignore writes.
// - A byte written to the bit reverse register reads back with its bit order mirrored.
// - Poly select zero uses the 32-bit polynomial, one the 16-bit polynomial.
// - The byte pointer steps after every read or write of the result port.
// - Writing one to the preset bit sets the result to all zeros or all ones.
// - The result holds until preset, overwritten through the port, or fed new data.
`include "crc_engine_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Byte FIFO between flash reads and the CRC fold
// ----------------------------------------------------------------------------
module crc_byte_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk_sys_i, // System clock.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire logic in_valid_i, // Write side offers a word.
  output logic in_ready_o, // Room for a word.
  input wire logic [WIDTH-1:0] in_data_i, // Word written.
  output logic out_valid_o, // A word is waiting.
  input wire logic out_ready_i, // Read side takes the word.
  output logic [WIDTH-1:0] out_data_o // Oldest word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] fill_reg;
  wire logic push = in_valid_i && in_ready_o;
  wire logic pop = out_valid_o && out_ready_i;

  // Full and empty come straight from the fill count.
  assign in_ready_o = (fill_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (fill_reg != '0);
  assign out_data_o = mem[rd_ptr_reg];
  // Storage has no reset, only the pointers and the fill count do.
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end
  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      fill_reg <= fill_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------------------------------------------
// CRC engine top
// ----------------------------------------------------------------------------
module crc_engine_auto_flash_scan
  import crc_engine_pkg::*;
(
  input wire logic clk_sys_i, // System clock, 100 MHz.
  input wire logic rst_n_i, // Synchronous reset, active low.
  input wire sfr_req_t sfr_req_i, // Register access from the core.
  output logic [7:0] sfr_rdata_o, // Read data, one cycle after the read.
  output logic cpu_stall_o, // Holds the core while a scan runs.
  input wire logic [1:0] fetch_bank_select_i, // Upper bank choice from the bank register.
  output logic flash_req_o, // Flash read request.
  output logic [16:0] flash_addr_o, // Flash byte address of the request.
  input wire logic flash_gnt_i, // Flash controller took the request.
  input wire flash_rsp_t flash_rsp_i // Flash read data return.
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [31:0] result_reg;
  logic [31:0] result_next;
  logic poly_width_select_reg;
  logic preset_value_select_reg;
  logic [1:0] result_byte_pointer_reg;
  logic auto_scan_enable_reg;
  logic [5:0] start_sector_reg;
  logic [5:0] auto_sector_count_reg;
  logic [7:0] byte_input_reg;
  logic [7:0] bit_reverse_reg;
  logic [7:0] rdata_reg;
  scan_state_t state_reg;
  scan_state_t state_next;
  logic [15:0] scan_addr_reg;
  logic [16:0] scan_left_reg;
  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  wire logic wr_port = sfr_req_i.wr && (sfr_req_i.addr == `ADDR_RESULT_PORT);
  wire logic rd_port = sfr_req_i.rd && (sfr_req_i.addr == `ADDR_RESULT_PORT);
  wire logic wr_ctl = sfr_req_i.wr && (sfr_req_i.addr == `ADDR_CRC_CONTROL);
  wire logic wr_in = sfr_req_i.wr && (sfr_req_i.addr == `ADDR_BYTE_INPUT);
  wire logic wr_rev = sfr_req_i.wr && (sfr_req_i.addr == `ADDR_BIT_REVERSE);
  wire logic wr_auto = sfr_req_i.wr && (sfr_req_i.addr == `ADDR_AUTO_CONTROL);
  wire logic wr_cnt = sfr_req_i.wr && (sfr_req_i.addr == `ADDR_SECTOR_COUNT);
  wire logic preset_req = wr_ctl && sfr_req_i.wdata[`CTL_PRESET_BIT];
  wire logic scan_idle = (state_reg == SCAN_IDLE);
  wire logic launch = wr_ctl && auto_scan_enable_reg && scan_idle;
  // --------------------------------------------------------------------------
  // Byte selection through the pointer
  // --------------------------------------------------------------------------
  // In 16-bit mode pointer values 2 and 3 alias bytes 0 and 1.
  wire logic [1:0] byte_sel = poly_width_select_reg ?
                              {1'b0, result_byte_pointer_reg[0]} :
                              result_byte_pointer_reg;
  wire logic [7:0] result_byte = result_reg[{byte_sel, 3'b000} +: 8];

  // --------------------------------------------------------------------------
  // Scan range
  // --------------------------------------------------------------------------
  // Start and count both zero mean the whole banked space.
  wire logic full_space = (start_sector_reg == '0) && (auto_sector_count_reg == '0);
  wire logic [6:0] sectors = full_space ? `FULL_SPACE_SECTORS :
                             {1'b0, auto_sector_count_reg};
  wire logic [16:0] scan_bytes = {sectors, 10'h000};
  wire logic [15:0] start_addr = {start_sector_reg, 10'h000};
  // Sectors 32 to 63 sit in the upper half and take the bank select.
  assign flash_addr_o = scan_addr_reg[15] ?
                        {fetch_bank_select_i, scan_addr_reg[14:0]} :
                        {2'b00, scan_addr_reg[14:0]};

  // --------------------------------------------------------------------------
  // Flash data FIFO
  // --------------------------------------------------------------------------
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  wire logic fifo_push = (state_reg == SCAN_WAIT) && flash_rsp_i.valid;
  // A core write to the byte input takes the fold, so the FIFO waits a cycle.
  wire logic fifo_out_ready = !(wr_in || wr_port || preset_req);
  wire logic fifo_pop = fifo_out_valid && fifo_out_ready;
  crc_byte_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) crc_byte_fifo_i (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(flash_rsp_i.data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );
  // --------------------------------------------------------------------------
  // CRC byte fold, most significant bit first
  // --------------------------------------------------------------------------
  function automatic logic [31:0] crc_fold(
    input logic [31:0] crc,
    input logic [7:0] data,
    input logic sel16
  );
    logic [31:0] c32;
    logic [15:0] c16;
    c32 = crc;
    c16 = crc[15:0];
    for (int i = 7; i >= 0; i--)
    begin
      c32 = (c32[31] ^ data[i]) ? ((c32 << 1) ^ `POLY_32) : (c32 << 1);
      c16 = (c16[15] ^ data[i]) ? ((c16 << 1) ^ `POLY_16) : (c16 << 1);
    end
    return sel16 ? {16'h0000, c16} : c32;
  endfunction
  // Preset wins, then a port write, then core data, then scanned data.
  always_comb
  begin
    result_next = result_reg;
    if (preset_req)
    begin
      result_next = sfr_req_i.wdata[`CTL_PRESET_VAL_BIT] ? `PRESET_ONES : `RST_RESULT;
    end
    else if (wr_port)
    begin
      result_next[{byte_sel, 3'b000} +: 8] = sfr_req_i.wdata;
    end
    else if (wr_in)
    begin
      result_next = crc_fold(result_reg, sfr_req_i.wdata, poly_width_select_reg);
    end
    else if (fifo_pop)
    begin
      result_next = crc_fold(result_reg, fifo_out_data, poly_width_select_reg);
    end
  end

  // The preset value in a control write applies to that same write.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      result_reg <= `RST_RESULT;
    end
    else
    begin
      result_reg <= result_next;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  // A port access after a control write uses the pointer just written.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      poly_width_select_reg <= 1'b0;
      preset_value_select_reg <= 1'b0;
      result_byte_pointer_reg <= 2'b00;
    end
    else if (wr_ctl)
    begin
      poly_width_select_reg <= sfr_req_i.wdata[`CTL_POLY_SEL_BIT];
      preset_value_select_reg <= sfr_req_i.wdata[`CTL_PRESET_VAL_BIT];
      result_byte_pointer_reg <= sfr_req_i.wdata[1:0];
    end
    else if (wr_port || rd_port)
    begin
      result_byte_pointer_reg <= result_byte_pointer_reg + 2'b01;
    end
  end

  // Scan setup, byte input and bit reverse registers.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      auto_scan_enable_reg <= 1'b0;
      start_sector_reg <= '0;
      auto_sector_count_reg <= '0;
      byte_input_reg <= `RST_BYTE;
      bit_reverse_reg <= `RST_BYTE;
    end
    else
    begin
      if (wr_auto)
      begin
        auto_scan_enable_reg <= sfr_req_i.wdata[`AUTO_ENABLE_BIT];
        start_sector_reg <= sfr_req_i.wdata[5:0];
      end
      if (wr_cnt)
      begin
        auto_sector_count_reg <= sfr_req_i.wdata[5:0];
      end
      if (wr_in)
      begin
        byte_input_reg <= sfr_req_i.wdata;
      end
      if (wr_rev)
      begin
        bit_reverse_reg <= {<<{sfr_req_i.wdata}};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // The preset bit acts on write only and reads as zero.
  wire logic [7:0] ctl_rd = {3'b000, poly_width_select_reg, 1'b0,
                             preset_value_select_reg, result_byte_pointer_reg};
  wire logic [7:0] auto_rd = {auto_scan_enable_reg, scan_idle, start_sector_reg};
  logic [7:0] rd_mux;
  always_comb
  begin
    case (sfr_req_i.addr)
      `ADDR_RESULT_PORT: rd_mux = result_byte;
      `ADDR_CRC_CONTROL: rd_mux = ctl_rd;
      `ADDR_BYTE_INPUT: rd_mux = byte_input_reg;
      `ADDR_BIT_REVERSE: rd_mux = bit_reverse_reg;
      `ADDR_AUTO_CONTROL: rd_mux = auto_rd;
      `ADDR_SECTOR_COUNT: rd_mux = {2'b00, auto_sector_count_reg};
      default: rd_mux = 8'h00;
    endcase
  end
  // Read data is registered and holds until the next read.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg <= 8'h00;
    end
    else if (sfr_req_i.rd)
    begin
      rdata_reg <= rd_mux;
    end
  end
  assign sfr_rdata_o = rdata_reg;
  // --------------------------------------------------------------------------
  // Automatic scan sequencer
  // --------------------------------------------------------------------------
  // One flash read is in flight at a time; a request waits for FIFO room,
  // which keeps the flash side stalled if the fold ever falls behind.
  wire logic last_byte = (scan_left_reg == 17'h00001);
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SCAN_IDLE: if (launch) state_next = (scan_bytes == '0) ? SCAN_DRAIN : SCAN_REQ;
      SCAN_REQ: if (flash_gnt_i && fifo_in_ready) state_next = SCAN_WAIT;
      SCAN_WAIT: if (flash_rsp_i.valid) state_next = last_byte ? SCAN_DRAIN : SCAN_REQ;
      SCAN_DRAIN: if (!fifo_out_valid) state_next = SCAN_IDLE;
      default: state_next = SCAN_IDLE;
    endcase
  end
  // Address steps upward one byte per returned read.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= SCAN_IDLE;
      scan_addr_reg <= '0;
      scan_left_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (launch)
      begin
        scan_addr_reg <= start_addr;
        scan_left_reg <= scan_bytes;
      end
      else if (fifo_push)
      begin
        scan_addr_reg <= scan_addr_reg + 16'h0001;
        scan_left_reg <= scan_left_reg - 17'h00001;
      end
    end
  end

  assign flash_req_o = (state_reg == SCAN_REQ) && fifo_in_ready;
  // The stall rises with the launch write itself so no instruction slips by.
  assign cpu_stall_o = launch || !scan_idle;

endmodule

`default_nettype wire

// ===== dv/crc_scan_checker_asserts.sv
// Purpose: Port checker for the CRC engine.
// Assumes: One clock domain; bound to the engine top.
// Notes: Helper flops shadow a few register writes.
`include "crc_engine_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module crc_scan_checker
  import crc_engine_pkg::*;
(
  input wire logic clk_sys_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire sfr_req_t sfr_req_i, // Register access.
  input wire logic [7:0] sfr_rdata_o, // Read data.
  input wire logic cpu_stall_o, // Core stall.
  input wire logic [1:0] fetch_bank_select_i, // Bank choice.
  input wire logic flash_req_o, // Flash request.
  input wire logic [16:0] flash_addr_o, // Flash address.
  input wire logic flash_gnt_i, // Flash grant.
  input wire flash_rsp_t flash_rsp_i // Flash data.
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Access decodes and the flash handshake.
  wire wr_ctl = sfr_req_i.wr && sfr_req_i.addr == `ADDR_CRC_CONTROL;
  wire wr_auto = sfr_req_i.wr && sfr_req_i.addr == `ADDR_AUTO_CONTROL;
  wire wr_flip = sfr_req_i.wr && sfr_req_i.addr == `ADDR_BIT_REVERSE;
  wire rd_flip = sfr_req_i.rd && sfr_req_i.addr == `ADDR_BIT_REVERSE;
  wire rd_auto = sfr_req_i.rd && sfr_req_i.addr == `ADDR_AUTO_CONTROL;
  wire rd_cnt = sfr_req_i.rd && sfr_req_i.addr == `ADDR_SECTOR_COUNT;
  wire grant = flash_req_o && flash_gnt_i;
  logic en_reg;
  logic busy_reg;
  logic have_reg;
  logic [7:0] flip_reg;
  logic [14:0] prev_reg;
  wire [7:0] flip_rev = {<<{flip_reg}};
  // Shadows; the previous address is forgotten between scans so a new start is not a step.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      en_reg <= 1'b0;
      busy_reg <= 1'b0;
      have_reg <= 1'b0;
      flip_reg <= 8'h00;
      prev_reg <= 15'h0000;
    end
    else
    begin
      if (wr_auto) en_reg <= sfr_req_i.wdata[7];
      if (wr_flip) flip_reg <= sfr_req_i.wdata;
      if (flash_rsp_i.valid) busy_reg <= 1'b0;
      if (grant) busy_reg <= 1'b1;
      if (grant) prev_reg <= flash_addr_o[14:0];
      have_reg <= grant || (have_reg && cpu_stall_o);
    end
  end
  launch_stall_a:
    assert property (wr_ctl && en_reg |-> cpu_stall_o) else $error("No stall on launch.");
  req_in_stall_a:
    assert property (flash_req_o |-> cpu_stall_o) else $error("Request without stall.");
  req_hold_a:
    assert property (flash_req_o && !flash_gnt_i |=> flash_req_o && $stable(flash_addr_o))
      else $error("Request dropped early.");
  one_outstanding_a:
    assert property (busy_reg |-> !flash_req_o) else $error("Second request outstanding.");
  addr_ascend_a:
    assert property (grant && have_reg |-> flash_addr_o[14:0] == prev_reg + 15'h0001)
      else $error("Address not ascending.");
  bank_addr_a:
    assert property (flash_req_o && flash_addr_o[16:15] != 2'b00
      |-> flash_addr_o[16:15] == fetch_bank_select_i) else $error("Wrong bank.");
  rdata_hold_a:
    assert property (!sfr_req_i.rd |=> $stable(sfr_rdata_o)) else $error("Read data moved.");
  flip_read_a:
    assert property (rd_flip |=> sfr_rdata_o == flip_rev) else $error("Bad reversed byte.");
  count_upper_a:
    assert property (rd_cnt |=> sfr_rdata_o[7:6] == 2'b00) else $error("Count top bits set.");
  done_read_a:
    assert property (rd_auto && !cpu_stall_o |=> sfr_rdata_o[6]) else $error("Complete flag low.");
  // Main scenarios reached.
  cover property (wr_ctl && en_reg);
  cover property (grant && have_reg);
  cover property (flash_rsp_i.valid);
endmodule
bind crc_engine_auto_flash_scan crc_scan_checker crc_scan_checker_i (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sfr_req_i(sfr_req_i),
  .sfr_rdata_o(sfr_rdata_o), .cpu_stall_o(cpu_stall_o),
  .fetch_bank_select_i(fetch_bank_select_i), .flash_req_o(flash_req_o),
  .flash_addr_o(flash_addr_o), .flash_gnt_i(flash_gnt_i), .flash_rsp_i(flash_rsp_i));
`default_nettype wire

// ===== dv/flash_partner.sv
// Purpose: Behavioural flash controller facing the engine.
// Assumes: One read outstanding; data is a fixed function of the address.
// Notes: Slow mode grants every other cycle and answers late.
`timescale 1ns/1ps
`default_nettype none
module flash_partner
  import crc_engine_pkg::*;
(
  input wire logic clk_sys_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic slow_i, // Stall the engine.
  input wire logic flash_req_i, // Read request.
  input wire logic [16:0] flash_addr_i, // Byte address.
  output logic flash_gnt_o, // Request taken.
  output var flash_rsp_t flash_rsp_o // Read return.
);
  logic tick_reg;
  logic pend_reg;
  logic [1:0] wait_reg;
  logic [16:0] addr_reg;
  assign flash_gnt_o = flash_req_i && (!slow_i || tick_reg);
  // Data outside a valid pulse is inverted each cycle so a stale byte never looks good.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      tick_reg <= 1'b0;
      pend_reg <= 1'b0;
      wait_reg <= 2'd0;
      addr_reg <= 17'h00000;
      flash_rsp_o <= '0;
    end
    else
    begin
      tick_reg <= !tick_reg;
      flash_rsp_o <= {1'b0, ~flash_rsp_o.data};
      if (pend_reg && wait_reg == 2'd0)
      begin
        flash_rsp_o <= {1'b1, addr_reg[7:0] ^ {addr_reg[16:13], addr_reg[11:8]}};
        pend_reg <= 1'b0;
      end
      else if (pend_reg) wait_reg <= wait_reg - 2'd1;
      else if (flash_gnt_o)
      begin
        pend_reg <= 1'b1;
        addr_reg <= flash_addr_i;
        wait_reg <= slow_i ? 2'd2 : 2'd0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/crc_engine_auto_flash_scan_test.sv
// Purpose: Self-checking bench for the CRC engine.
// Assumes: Inputs change on the falling edge; a flash model answers reads.
// Notes: The whole-space scan is cut short by a mid-run reset to keep the run short.
`include "crc_engine_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module crc_engine_auto_flash_scan_test
  import crc_engine_pkg::*;
;
  logic clk_sys_i, rst_n_i, slow, stall, freq, gnt;
  logic [1:0] bank;
  logic [7:0] rdata, v;
  logic [16:0] faddr, first_addr;
  sfr_req_t req;
  flash_rsp_t frsp;
  int n_fail, n_compared, n_bytes;
  crc_engine_auto_flash_scan crc_engine_auto_flash_scan_i (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .sfr_req_i(req), .sfr_rdata_o(rdata), .cpu_stall_o(stall),
    .fetch_bank_select_i(bank), .flash_req_o(freq), .flash_addr_o(faddr),
    .flash_gnt_i(gnt), .flash_rsp_i(frsp));
  flash_partner flash_partner_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(slow),
    .flash_req_i(freq), .flash_addr_i(faddr), .flash_gnt_o(gnt), .flash_rsp_o(frsp));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Counts granted reads and keeps the first address of a scan.
  always @(posedge clk_sys_i)
  begin
    if (freq && gnt)
    begin
      if (n_bytes == 0) first_addr = faddr;
      n_bytes++;
    end
  end
  task test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One access per call; the idle cycle between calls keeps strobes single-edged.
  task sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    req = '{a, 1'b1, 1'b0, d};
    @(negedge clk_sys_i);
    req = '0;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_i);
    req = '{a, 1'b0, 1'b1, 8'h00};
    @(negedge clk_sys_i);
    req = '0;
    chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, rdata});
  endtask
  // Reads four result bytes through the port; bytes wrap in 16-bit mode.
  task result_chk(input logic [31:0] e, input logic s16);
    for (int k = 0; k < 4; k++)
      rchk(`ADDR_RESULT_PORT, s16 ? e[8*(k%2)+:8] : e[8*k+:8]);
  endtask
  function automatic logic [31:0] fold(input logic [31:0] c, input logic [7:0] d,
    input logic s16);
    logic [31:0] r;
    r = s16 ? {16'h0000, c[15:8] ^ d, c[7:0]} : {c[31:24] ^ d, c[23:0]};
    repeat (8)
      r = s16 ? {16'h0000, r[14:0], 1'b0} ^ (r[15] ? {16'h0000, `POLY_16} : 32'h0)
        : {r[30:0], 1'b0} ^ (r[31] ? `POLY_32 : 32'h0);
    return r;
  endfunction
  // The port read at 0x91 steps the pointer, so the control register then reads 0x01.
  task automatic reset_values;
    logic [7:0] a[7] = '{8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97};
    logic [7:0] e[7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
    for (int k = 0; k < 7; k++)
      rchk(a[k], e[k]);
  endtask
  task misc_regs;
    sfr_wr(`ADDR_BIT_REVERSE, 8'hC0);
    rchk(`ADDR_BIT_REVERSE, 8'h03);
    sfr_wr(`ADDR_BIT_REVERSE, 8'h05);
    rchk(`ADDR_BIT_REVERSE, 8'hA0);
    sfr_wr(`ADDR_SECTOR_COUNT, 8'hFF);
    rchk(`ADDR_SECTOR_COUNT, 8'h3F);
    sfr_wr(8'h95, 8'hFF);
    rchk(8'h95, 8'h00);
  endtask
  // Presets to ones, folds four bytes, then reads a fifth time to see the pointer wrap.
  task byte_crc(input logic s16);
    logic [31:0] e;
    e = 32'hFFFFFFFF;
    sfr_wr(`ADDR_CRC_CONTROL, s16 ? 8'h1C : 8'h0C);
    for (int k = 0; k < 4; k++)
    begin
      sfr_wr(`ADDR_BYTE_INPUT, 8'h31 + k[7:0]);
      e = fold(e, 8'h31 + k[7:0], s16);
    end
    result_chk(e, s16);
    rchk(`ADDR_RESULT_PORT, e[7:0]);
  endtask
  task port_write;
    sfr_wr(`ADDR_CRC_CONTROL, 8'h00);
    for (int k = 0; k < 4; k++)
      sfr_wr(`ADDR_RESULT_PORT, 8'h11 * (k[7:0] + 8'h01));
    sfr_wr(`ADDR_BYTE_INPUT, 8'hA5);
    result_chk(fold(32'h44332211, 8'hA5, 1'b0), 1'b0);
  endtask
  // Scan with zero preset in the launch write; expectation rebuilt from the address map.
  task scan(input logic [5:0] st, input logic [5:0] cnt, input logic [1:0] bk, input logic sl);
    logic [31:0] e;
    logic [15:0] a;
    e = 32'h0;
    bank = bk;
    slow = sl;
    sfr_wr(`ADDR_SECTOR_COUNT, {2'b00, cnt});
    sfr_wr(`ADDR_AUTO_CONTROL, {2'b10, st});
    n_bytes = 0;
    sfr_wr(`ADDR_CRC_CONTROL, 8'h08);
    for (int i = 0; i < 40000 && stall; i++)
      @(negedge clk_sys_i);
    if (stall)
    begin
      n_fail++;
      $display("CHECK FAILED stall expected 0 seen 1");
      test_done;
    end
    for (int i = 0; i < 1024 * cnt; i++)
    begin
      a = {st, 10'h000} + i[15:0];
      faddr_exp(a, bk, v, i == 0);
      e = fold(e, v, 1'b0);
    end
    chk("sectors", 1024 * cnt, n_bytes);
    rchk(`ADDR_AUTO_CONTROL, {2'b11, st});
    result_chk(e, 1'b0);
    sfr_wr(`ADDR_AUTO_CONTROL, {2'b00, st});
  endtask
  // Byte the flash holds at a scan address; the first address is checked as well.
  task faddr_exp(input logic [15:0] a, input logic [1:0] bk, output logic [7:0] d,
    input logic first);
    logic [16:0] f;
    f = a[15] ? {bk, a[14:0]} : {2'b00, a[14:0]};
    d = f[7:0] ^ {f[16:13], f[11:8]};
    if (first) chk("first address", {15'h0, f}, {15'h0, first_addr});
  endtask
  // Start and count zero: still busy well past one sector, then a mid-run reset ends it.
  task full_cut;
    bank = 2'b00;
    slow = 1'b0;
    sfr_wr(`ADDR_SECTOR_COUNT, 8'h00);
    sfr_wr(`ADDR_AUTO_CONTROL, 8'h80);
    n_bytes = 0;
    sfr_wr(`ADDR_CRC_CONTROL, 8'h00);
    repeat (4000) @(negedge clk_sys_i);
    chk("full space stall", 32'h1, {31'h0, stall});
    chk("full space reads", 32'h1, {31'h0, n_bytes > 1024});
    chk("full space first address", 32'h0, {15'h0, first_addr});
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    chk("stall after reset", 32'h0, {31'h0, stall});
    rchk(`ADDR_AUTO_CONTROL, 8'h40);
  endtask
  initial
  begin
    n_fail = 0;
    n_compared = 0;
    n_bytes = 0;
    req = '0;
    bank = 2'b00;
    slow = 1'b0;
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    reset_values;
    misc_regs;
    byte_crc(1'b0);
    byte_crc(1'b1);
    port_write;
    scan(6'd2, 6'd1, 2'b00, 1'b0);
    scan(6'd33, 6'd2, 2'b10, 1'b1);
    full_cut;
    test_done;
  end
endmodule
`default_nettype wire
